// ### rtl/byp_defines.svh
// Fixed-point constants for the Bayer to 4:2:2 packer
`ifndef BYP_DEFINES_SVH
`define BYP_DEFINES_SVH

// Colour weights scaled by 2**8; each row of weights sums to 256 or 0
`define BYP_COEF_SHIFT 8
`define BYP_Y_R 20'sh0004D
`define BYP_Y_G 20'sh00097
`define BYP_Y_B 20'sh0001C
`define BYP_U_R 20'sh0002C
`define BYP_U_G 20'sh00054
`define BYP_U_B 20'sh00080
`define BYP_V_R 20'sh00080
`define BYP_V_G 20'sh00069
`define BYP_V_B 20'sh00017
`define BYP_ROUND_HALF 20'sh00080

// Output ranges
`define BYP_LUMA_MIN 20'sh00000
`define BYP_LUMA_MAX 20'sh000FF
`define BYP_CHROMA_MIN 20'shFFF80
`define BYP_CHROMA_MAX 20'sh0007F
`define BYP_CHROMA_OFFSET 8'h80
`define BYP_CHROMA_LOW 8'h00
`define BYP_CHROMA_HIGH 8'hFF
`define BYP_BYTES_PER_PAIR 3'h4

`endif

// ### rtl/byp_pkg.sv
// Types shared by the Bayer to 4:2:2 packer
package byp_pkg;
  typedef enum logic {
    BYP_CHROMA_FIRST_422_FORMAT,
    BYP_LUMA_FIRST_422_FORMAT
  } byp_fmt_t;

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] u;
    logic [7:0] v;
  } byp_yuv_t;
endpackage

// ### rtl/byp_mem_if.sv
// Line memory access carrier between packer and line store
`timescale 1ns/1ps
`default_nettype none
interface byp_mem_if #(
  parameter int AW = 11,
  parameter int DW = 8
);
  logic en;
  logic wr;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport ctrl (output en, output wr, output addr, output wdata,
                input rdata);
  modport mem (input en, input wr, input addr, input wdata,
               output rdata);
endinterface
`default_nettype wire

// ### rtl/byp_line_mem.sv
// One-line store of raw samples, read-before-write, registered read
`timescale 1ns/1ps
`default_nettype none
module byp_line_mem #(
  parameter int AW = 11,
  parameter int DW = 8
) (
  input wire logic clk_in,
  byp_mem_if.mem mem_port
);
  logic [DW-1:0] ram [2**AW];

  // Old contents come out while the new sample lands at the same column
  always_ff @(posedge clk_in) begin
    if (mem_port.en) begin
      mem_port.rdata <= ram[mem_port.addr];
      if (mem_port.wr) begin
        ram[mem_port.addr] <= mem_port.wdata;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/byp_packer.sv
// Bayer demosaic, RGB to YUV conversion and 4:2:2 byte packer
// Behaviour
// - Demosaic every pixel to full RGB first
// - Luma is 0.30 R, 0.59 G, 0.11 B
// - U is 0.50 B minus 0.17 R, 0.33 G
// - V is 0.50 R minus 0.41 G, 0.09 B
// - Add 128 to each signed chroma value
// - Chroma-first order: U0 Y0 V0 Y1
// - Luma-first order: Y0 U0 Y1 V0
// - Luma every paired pixel, chroma of even pixel only
// - Both orders carry identical component values
// - Luma byte is plain unsigned 0 to 255
// - Chroma byte is offset binary, 0x80 is zero
`timescale 1ns/1ps
`default_nettype none
`include "byp_defines.svh"
module byp_packer #(
  parameter int LINE_MAX = 2048
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [7:0] pix_data_in,
  input wire logic pix_valid_in,
  input wire logic pix_sof_in,
  input wire logic pix_eol_in,
  output logic pix_ready_out,
  input wire logic luma_first_422_format_in,
  output logic [7:0] byte_data_out,
  output logic byte_valid_out,
  input wire logic byte_ready_in
);
  localparam int AW = $clog2(LINE_MAX);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  // Position tracking of the incoming raster
  logic [AW-1:0] col;
  logic row_odd;
  logic first_row;
  logic adv;
  wire logic acc = pix_valid_in && pix_ready_out;
  wire logic [AW-1:0] pos_col = pix_sof_in ? '0 : col;
  wire logic pos_row_odd = pix_sof_in ? 1'b0 : row_odd;
  wire logic pos_first_row = pix_sof_in ? 1'b1 : first_row;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      col <= '0;
      row_odd <= 1'b0;
      first_row <= 1'b1;
    end else if (acc) begin
      col <= pix_eol_in ? '0 : pos_col + AW'(1);
      row_odd <= pix_eol_in ? !pos_row_odd : pos_row_odd;
      first_row <= pix_eol_in ? 1'b0 : pos_first_row;
    end
  end

  // Previous line comes back one cycle later, aligned with stage 1
  byp_mem_if #(.AW(AW), .DW(8)) lb ();
  byp_line_mem #(.AW(AW), .DW(8)) u_line_mem (
    .clk_in(clk_in),
    .mem_port(lb.mem)
  );
  assign lb.en = adv;
  assign lb.wr = acc;
  assign lb.addr = pos_col;
  assign lb.wdata = pix_data_in;

  // Stage 1: 2x2 window of up-left, up, left and current samples
  logic s1_valid;
  logic [7:0] s1_d;
  logic s1_col_odd;
  logic s1_row_odd;
  logic s1_first_row;
  logic s1_first_col;
  logic [7:0] lft_up;
  logic [7:0] lft_cur;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1_valid <= 1'b0;
      s1_d <= 8'h00;
      s1_col_odd <= 1'b0;
      s1_row_odd <= 1'b0;
      s1_first_row <= 1'b1;
      s1_first_col <= 1'b1;
    end else if (adv) begin
      s1_valid <= acc;
      s1_d <= pix_data_in;
      s1_col_odd <= pos_col[0];
      s1_row_odd <= pos_row_odd;
      s1_first_row <= pos_first_row;
      s1_first_col <= (pos_col == '0);
    end
  end

  // Edges see black neighbours: cheap, and no extra line of latency
  wire logic [7:0] win_d = s1_d;
  wire logic [7:0] win_b = s1_first_row ? 8'h00 : lb.rdata;
  wire logic [7:0] win_a = s1_first_col ? 8'h00 : lft_up;
  wire logic [7:0] win_c = s1_first_col ? 8'h00 : lft_cur;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      lft_up <= 8'h00;
      lft_cur <= 8'h00;
    end else if (adv && s1_valid) begin
      lft_up <= win_b;
      lft_cur <= win_d;
    end
  end

  // Sensor phase: even rows B G, odd rows G R
  wire logic [1:0] ph = {s1_row_odd, s1_col_odd};
  wire logic [8:0] gsum_bc = {1'b0, win_b} + {1'b0, win_c};
  wire logic [8:0] gsum_ad = {1'b0, win_a} + {1'b0, win_d};
  wire logic [7:0] dm_r = (ph == 2'h0) ? win_a : (ph == 2'h1) ? win_b :
                          (ph == 2'h2) ? win_c : win_d;
  wire logic [7:0] dm_g = (ph == 2'h0 || ph == 2'h3) ? gsum_bc[8:1] :
                          gsum_ad[8:1];
  wire logic [7:0] dm_b = (ph == 2'h0) ? win_d : (ph == 2'h1) ? win_c :
                          (ph == 2'h2) ? win_b : win_a;

  sequence s_gray;
    s1_valid && dm_r == dm_g && dm_g == dm_b;
  endsequence

  a_demosaic_blue_site: assert property (
    s1_valid && ph == 2'h0 |-> dm_b == s1_d && dm_r == win_a &&
      dm_g == gsum_bc[8:1])
    else $error("blue site not demosaiced from its window");

  // Colour conversion in 8.8 fixed point
  wire logic signed [19:0] ex_r = $signed({12'h000, dm_r});
  wire logic signed [19:0] ex_g = $signed({12'h000, dm_g});
  wire logic signed [19:0] ex_b = $signed({12'h000, dm_b});
  wire logic signed [19:0] acc_y = `BYP_Y_R * ex_r + `BYP_Y_G * ex_g +
                                   `BYP_Y_B * ex_b + `BYP_ROUND_HALF;
  wire logic signed [19:0] acc_u = `BYP_U_B * ex_b - `BYP_U_R * ex_r -
                                   `BYP_U_G * ex_g + `BYP_ROUND_HALF;
  wire logic signed [19:0] acc_v = `BYP_V_R * ex_r - `BYP_V_G * ex_g -
                                   `BYP_V_B * ex_b + `BYP_ROUND_HALF;
  wire logic signed [19:0] rnd_y = acc_y >>> `BYP_COEF_SHIFT;
  wire logic signed [19:0] rnd_u = acc_u >>> `BYP_COEF_SHIFT;
  wire logic signed [19:0] rnd_v = acc_v >>> `BYP_COEF_SHIFT;

  function automatic logic [7:0] sat_luma(input logic signed [19:0] v);
    if (v < `BYP_LUMA_MIN) begin
      return 8'h00;
    end else if (v > `BYP_LUMA_MAX) begin
      return 8'hFF;
    end
    return v[7:0];
  endfunction

  // Offset after clamping, so -128..127 maps onto 0x00..0xFF
  function automatic logic [7:0] sat_chroma(input logic signed [19:0] v);
    if (v < `BYP_CHROMA_MIN) begin
      return `BYP_CHROMA_LOW;
    end else if (v > `BYP_CHROMA_MAX) begin
      return `BYP_CHROMA_HIGH;
    end
    return v[7:0] + `BYP_CHROMA_OFFSET;
  endfunction

  byp_pkg::byp_yuv_t next_yuv;
  assign next_yuv.y = sat_luma(rnd_y);
  assign next_yuv.u = sat_chroma(rnd_u);
  assign next_yuv.v = sat_chroma(rnd_v);

  a_gray_luma_unity: assert property (
    s_gray |-> next_yuv.y == dm_r)
    else $error("grey input did not give equal luma");
  a_gray_chroma_mid: assert property (
    s_gray |-> next_yuv.u == `BYP_CHROMA_OFFSET &&
      next_yuv.v == `BYP_CHROMA_OFFSET)
    else $error("grey input did not give mid chroma");
  a_red_chroma_sat: assert property (
    s1_valid && dm_r == 8'hFF && dm_g == 8'h00 && dm_b == 8'h00 |->
      next_yuv.u == 8'h54 && next_yuv.v == 8'hFF && next_yuv.y == 8'h4D)
    else $error("pure red converted wrongly");

  // Stage 2: converted pixel
  logic s2_valid;
  logic s2_col_odd;
  byp_pkg::byp_yuv_t s2_yuv;
  byp_pkg::byp_yuv_t hold;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s2_valid <= 1'b0;
      s2_col_odd <= 1'b0;
      s2_yuv <= '0;
    end else if (adv) begin
      s2_valid <= s1_valid;
      s2_col_odd <= s1_col_odd;
      s2_yuv <= next_yuv;
    end
  end

  // Even pixel waits here; an unpaired one is overwritten by the next
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hold <= '0;
    end else if (adv && s2_valid && !s2_col_odd) begin
      hold <= s2_yuv;
    end
  end

  // Byte serialiser
  logic [7:0] bytes [4];
  logic [2:0] cnt;
  logic [7:0] next_bytes [4];
  wire logic ser_free = (cnt == 3'h0) ||
                        (cnt == 3'h1 && byte_ready_in);
  wire logic ser_load = adv && s2_valid && s2_col_odd;
  wire logic fmt_luma_first = (byp_pkg::byp_fmt_t'(luma_first_422_format_in)
                               == byp_pkg::BYP_LUMA_FIRST_422_FORMAT);
  wire logic shift = byte_valid_out && byte_ready_in;

  // Only the odd pixel of a pair can stall, as it needs the serialiser
  assign adv = !(s2_valid && s2_col_odd) || ser_free;
  assign pix_ready_out = adv;

  // Same four components, only the slots differ
  assign next_bytes[0] = fmt_luma_first ? hold.y : hold.u;
  assign next_bytes[1] = fmt_luma_first ? hold.u : hold.y;
  assign next_bytes[2] = fmt_luma_first ? s2_yuv.y : hold.v;
  assign next_bytes[3] = fmt_luma_first ? hold.v : s2_yuv.y;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        bytes[i] <= 8'h00;
      end
    end else if (ser_load) begin
      cnt <= `BYP_BYTES_PER_PAIR;
      bytes <= next_bytes;
    end else if (shift) begin
      cnt <= cnt - 3'h1;
      bytes[0] <= bytes[1];
      bytes[1] <= bytes[2];
      bytes[2] <= bytes[3];
    end
  end

  assign byte_valid_out = (cnt != 3'h0);
  assign byte_data_out = bytes[0];

  sequence s_load;
    ser_load;
  endsequence

  // Component totals before and after packing, for the same-values check
  wire logic [9:0] pair_sum = {2'h0, hold.u} + {2'h0, hold.v} +
                              {2'h0, hold.y} + {2'h0, s2_yuv.y};
  wire logic [9:0] ser_sum = {2'h0, bytes[0]} + {2'h0, bytes[1]} +
                             {2'h0, bytes[2]} + {2'h0, bytes[3]};

  a_chroma_first_order: assert property (
    s_load ##0 !fmt_luma_first |=> bytes[0] == $past(hold.u) &&
      bytes[1] == $past(hold.y) && bytes[2] == $past(hold.v) &&
      bytes[3] == $past(s2_yuv.y))
    else $error("chroma-first byte order wrong");
  a_luma_first_order: assert property (
    s_load ##0 fmt_luma_first |=> bytes[0] == $past(hold.y) &&
      bytes[1] == $past(hold.u) && bytes[2] == $past(s2_yuv.y) &&
      bytes[3] == $past(hold.v))
    else $error("luma-first byte order wrong");
  a_orders_same_values: assert property (
    s_load |=> ser_sum == $past(pair_sum))
    else $error("byte orders carry different values");
  a_pair_four_bytes: assert property (
    s_load ##1 !byte_ready_in [*3] |-> byte_valid_out && cnt == 3'h4)
    else $error("pair did not hold four bytes");
  a_only_odd_loads: assert property (
    $rose(cnt == 3'h4) |-> $past(s2_valid) && $past(s2_col_odd))
    else $error("serialiser loaded on an even pixel");
endmodule
`default_nettype wire

// ### bench/byp_host_sink.sv
// Host-side byte sink with optional random stalls
`timescale 1ns/1ps
`default_nettype none
module byp_host_sink (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic stall_in,
  input wire logic byte_valid_in,
  output logic byte_ready_out,
  output logic got_out
);
  logic [7:0] lfsr;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      lfsr <= 8'hA5;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end
  // Ready moves only after an edge; stalling refuses about half the bytes
  assign byte_ready_out = !stall_in || lfsr[0];
  assign got_out = byte_valid_in && byte_ready_out;
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the Bayer to 4:2:2 packer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int LMAX = 16;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] pix_data_in = 8'h00;
  logic pix_valid_in = 1'b0;
  logic pix_sof_in = 1'b0;
  logic pix_eol_in = 1'b0;
  logic pix_ready_out;
  logic fmt = 1'b0;
  logic [7:0] byte_data_out;
  logic byte_valid_out;
  logic byte_ready_in;
  logic stall = 1'b0;
  logic got;
  int bad_count = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h0D1215E9;
  logic [7:0] img [0:3][0:LMAX-1];
  logic [7:0] exp_q [$];
  logic [7:0] exp_b;

  always #2.5 clk_in = ~clk_in;

  byp_packer #(.LINE_MAX(LMAX)) i_byp_packer (.clk_in(clk_in),
    .srst_in(srst_in), .pix_data_in(pix_data_in),
    .pix_valid_in(pix_valid_in), .pix_sof_in(pix_sof_in),
    .pix_eol_in(pix_eol_in), .pix_ready_out(pix_ready_out),
    .luma_first_422_format_in(fmt), .byte_data_out(byte_data_out),
    .byte_valid_out(byte_valid_out), .byte_ready_in(byte_ready_in));
  byp_host_sink i_byp_host_sink (.clk_in(clk_in), .srst_in(srst_in),
    .stall_in(stall), .byte_valid_in(byte_valid_out),
    .byte_ready_out(byte_ready_in), .got_out(got));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic int px(input int r, input int c);
    return (r < 0 || c < 0) ? 0 : int'(img[r][c]);
  endfunction

  function automatic int cl(input int x, input int lo, input int hi);
    return x < lo ? lo : (x > hi ? hi : x);
  endfunction

  function automatic byp_pkg::byp_yuv_t yuv(input int r, input int c);
    int rb, cb, rr, cr, rv, gv, bv;
    byp_pkg::byp_yuv_t o;
    rb = r - r % 2;
    cb = c - c % 2;
    rr = r - 1 + r % 2;
    cr = c - 1 + c % 2;
    bv = px(rb, cb);
    rv = px(rr, cr);
    gv = (px(rb, cr) + px(rr, cb)) / 2;
    o.y = 8'(cl((77 * rv + 151 * gv + 28 * bv + 128) >>> 8, 0, 255));
    o.u = 8'(cl((-44 * rv - 84 * gv + 128 * bv + 128) >>> 8, -128, 127)
      + 128);
    o.v = 8'(cl((128 * rv - 105 * gv - 23 * bv + 128) >>> 8, -128, 127)
      + 128);
    return o;
  endfunction

  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tmo;
    bad_count++;
    $display("[ERR] t=%0t wait ran out exp=%h got=%h", $time, 1'b1, 1'b0);
    finish_test();
  endtask

  // Bytes leave in the order the pairs were pushed
  always @(posedge clk_in) begin
    if (got === 1'b1 && srst_in === 1'b0) begin
      exp_b = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
      chk_byte(exp_b, byte_data_out);
    end
  end

  task automatic send(input logic [7:0] d, input logic s, input logic e);
    int k;
    pix_data_in <= d;
    pix_sof_in <= s;
    pix_eol_in <= e;
    pix_valid_in <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (pix_ready_out !== 1'b1 && k < 300);
    if (pix_ready_out !== 1'b1) tmo();
  endtask

  task automatic run_frame(input int w, input int kind, input logic f);
    byp_pkg::byp_yuv_t a, b;
    int k;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < w; c++) begin
        seed = xs(seed);
        img[r][c] = kind == 0 ? seed[7:0] : kind == 1 ? 8'hFF :
          kind == 2 ? {8{r % 2 == 1 && c % 2 == 1}} :
          {8{r % 2 == 0 && c % 2 == 0}};
      end
      for (int c = 0; c + 1 < w; c += 2) begin
        a = yuv(r, c);
        b = yuv(r, c + 1);
        if (f) begin
          exp_q.push_back(a.y);
          exp_q.push_back(a.u);
          exp_q.push_back(b.y);
          exp_q.push_back(a.v);
        end else begin
          exp_q.push_back(a.u);
          exp_q.push_back(a.y);
          exp_q.push_back(a.v);
          exp_q.push_back(b.y);
        end
      end
    end
    fmt <= f;
    stall <= seed[9];
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < w; c++) begin
        send(img[r][c], r == 0 && c == 0, c == w - 1);
        seed = xs(seed);
        if (seed[3]) begin
          pix_valid_in <= 1'b0;
          @(posedge clk_in);
        end
      end
    end
    pix_valid_in <= 1'b0;
    k = 0;
    while (exp_q.size() > 0 && k < 2000) begin
      @(posedge clk_in);
      k++;
    end
    if (exp_q.size() > 0) tmo();
    $display("frame w=%0d kind=%0d fmt=%0d done", w, kind, f);
  endtask

  initial begin
    repeat (16) @(posedge clk_in);
    chk_byte(8'h00, {7'h00, byte_valid_out});
    chk_byte(8'h00, byte_data_out);
    chk_byte(8'h01, {7'h00, pix_ready_out});
    srst_in <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      run_frame(i == 3 ? 5 : 4 + 2 * (i % 3), i % 4, i >= 4);
    end
    finish_test();
  end
endmodule
`default_nettype wire
